// [design/wake_pkg.sv]
// shared constants and types of the wake event aggregator
// Notes on behaviour
// (RL1) enabled alarm turns supply on, sets status
// (RL2) alarm plus routing enable raises wake output
// (RL3) unrouted alarm raises smi when selected
// (RL4) alarm bypasses global wake enable
// (RL5) remembered missed alarm wakes after standby return
// (RL6) many sources can raise wake output
// (RL7) wake pin polarity and driver type selectable
// (RL8) global enable gates banked wake events
// (RL9) status sets on edge regardless of enable
// (RL10) summary is or of enabled status
// (RL11) gpio polarity picks rising or falling edge
// (RL12) either edge option sets on both edges
// (RL13) fan tachometer has status and enable
// (RL14) port sources falling edge, or both edges
// (RL15) both edges keep waking until cleared
// (RL16) port status write one clears, output drops
// (RL17) runtime registers follow programmable base address
// (RL18) banks split gpio, device, pin events
// (RL19) one scan code register, standby reset
// (RL20) key status and enable are bit five
// (RL21) frame starts with zero, data lsb first
// (RL22) odd parity then stop bit one
// (RL23) start after long high clock period
// (RL24) long high mid frame resets matcher
// (RL25) key logic off bit defaults clear
// (RL26) async sources pass two flip flops
package wake_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int KBD_IDLE_US = 115;
	localparam int KBD_IDLE_CYC = (KBD_IDLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NBANK = 7;
	localparam int NSRC = NBANK * 8;
	localparam int NSYNC = NSRC + 4;
	localparam int IDX_KBD_DATA = 2;
	localparam int IDX_KBD_CLK = NSRC;
	localparam int IDX_ALARM = NSRC + 1;
	localparam int IDX_PWRBTN = NSRC + 2;
	localparam int IDX_MISSED = NSRC + 3;
	localparam int PORT_BANK = 5;
	localparam logic [7:0] CFG_BASE_HI = 8'h60;
	localparam logic [7:0] CFG_BASE_LO = 8'h61;
	localparam logic [7:0] CFG_CLOCK = 8'hF0;
	localparam logic [7:0] CFG_SUPPLY = 8'hF8;
	localparam logic [6:0] RT_SUMMARY = 7'h00;
	localparam logic [6:0] RT_GLOBAL = 7'h01;
	localparam logic [6:0] RT_STS_BASE = 7'h08;
	localparam logic [6:0] RT_EN_BASE = 7'h10;
	localparam logic [6:0] RT_SMI_CTRL = 7'h17;
	localparam logic [6:0] RT_ACPI_EVENT_STATUS_REG = 7'h18;
	localparam logic [6:0] RT_PM1_EN = 7'h19;
	localparam logic [6:0] RT_EDGE_SEL = 7'h21;
	localparam logic [6:0] RT_PIN_CTRL = 7'h30;
	localparam logic [6:0] RT_POL_BASE = 7'h40;
	localparam logic [6:0] RT_EE_BASE = 7'h48;
	localparam logic [6:0] RT_SCAN = 7'h5F;
	localparam logic [6:0] RT_SCI_CTRL = 7'h60;
	localparam int SUP_PSOFF_BIT = 0;
	localparam int SUP_REMEMBER_BIT = 5;
	localparam int SUP_SEL_N_BIT = 6;
	localparam int CLK_KEY_OFF_BIT = 1;
	localparam int PIN_POL_HIGH_BIT = 1;
	localparam int PIN_PUSH_PULL_BIT = 7;
	localparam int SMI_OE_BIT = 7;
	localparam int SCI_ROUTE_ENABLE_BIT = 0;
	localparam int GLOBAL_EN_BIT = 0;
	localparam int PM1_PWRBTN_BIT = 0;
	localparam int PM1_ALARM_BIT = 2;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] BANK1_POL = 8'h0F;
	localparam logic [7:0] BANK6_POL = 8'hC0;
	localparam logic [3:0] FRAME_DATA_LAST = 4'h8;
	localparam logic [3:0] FRAME_PARITY_POS = 4'h9;
	localparam logic [3:0] FRAME_STOP_POS = 4'hA;
	typedef struct packed {
		logic        cfg;
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  data;
	} io_req_s;
	typedef enum {KEY_WAIT_IDLE, KEY_ARMED, KEY_RECEIVE} key_state_e;
endpackage

// [design/wake_edge_detect.sv]
// two-stage synchroniser with edge detection for a vector of async inputs
module wake_edge_detect #(
	parameter int W = 1
) (
	input  wire logic         core_clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic [W-1:0] raw_i,
	output logic [W-1:0]      level_o,
	output logic [W-1:0]      rise_o,
	output logic [W-1:0]      fall_o
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;
	logic [W-1:0] last_reg;

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
			last_reg <= '0;
		end else begin
			meta_reg <= raw_i; // RL26
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign level_o = sync_reg;
	assign rise_o = sync_reg & ~last_reg;
	assign fall_o = ~sync_reg & last_reg;
endmodule // wake_edge_detect

// [design/key_code_matcher.sv]
// frame matcher that spots one programmed keyboard scan code
module key_code_matcher import wake_pkg::*; #(
	parameter int IDLE_CYCLES = KBD_IDLE_CYC
) (
	input  wire logic       core_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       kbd_clk_i,
	input  wire logic       kbd_fall_i,
	input  wire logic       kbd_data_i,
	input  wire logic [7:0] scan_code_i,
	input  wire logic       key_off_i,
	output logic            match_o
);
	localparam int CW = $clog2(IDLE_CYCLES + 1);
	key_state_e    state_reg, state_next;
	logic [CW-1:0] high_reg, high_next;
	logic [3:0]    bit_reg, bit_next;
	logic [7:0]    shift_reg, shift_next;
	logic          par_reg, par_next;
	logic          match_reg, match_next;
	logic          idle_met;

	assign idle_met = high_reg == CW'(IDLE_CYCLES);
	// held at zero while off so the counter draws nothing
	assign high_next = (key_off_i || !kbd_clk_i) ? CW'(0) : idle_met ? high_reg : high_reg + CW'(1);

	always_comb begin
		state_next = state_reg;
		bit_next = bit_reg;
		shift_next = shift_reg;
		par_next = par_reg;
		match_next = 1'h0;
		case (state_reg)
			KEY_WAIT_IDLE: begin
				if (idle_met)
					state_next = KEY_ARMED; // RL23
			end
			KEY_ARMED: begin
				if (kbd_fall_i) begin
					state_next = kbd_data_i ? KEY_WAIT_IDLE : KEY_RECEIVE; // RL21
					bit_next = 4'h1;
					par_next = 1'h0;
				end
			end
			KEY_RECEIVE: begin
				if (idle_met) begin
					state_next = KEY_WAIT_IDLE; // RL24
				end else if (kbd_fall_i) begin
					bit_next = bit_reg + 4'h1;
					if (bit_reg <= FRAME_DATA_LAST)
						shift_next = {kbd_data_i, shift_reg[7:1]}; // RL21
					if (bit_reg <= FRAME_PARITY_POS)
						par_next = par_reg ^ kbd_data_i;
					if (bit_reg == FRAME_STOP_POS) begin
						state_next = KEY_WAIT_IDLE;
						match_next = kbd_data_i && par_reg && shift_reg == scan_code_i; // RL22
					end
				end
			end
			default: state_next = KEY_WAIT_IDLE;
		endcase
		if (key_off_i) begin
			state_next = KEY_WAIT_IDLE; // RL25
			match_next = 1'h0;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= KEY_WAIT_IDLE;
			high_reg <= CW'(0);
			bit_reg <= 4'h0;
			shift_reg <= 8'h00;
			par_reg <= 1'h0;
			match_reg <= 1'h0;
		end else begin
			state_reg <= state_next;
			high_reg <= high_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			par_reg <= par_next;
			match_reg <= match_next;
		end
	end

	assign match_o = match_reg;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence stop_edge_s;
		state_reg == KEY_RECEIVE && bit_reg == FRAME_STOP_POS && kbd_fall_i && !idle_met && !key_off_i;
	endsequence
	sequence good_frame_s;
		kbd_data_i && par_reg && shift_reg == scan_code_i;
	endsequence

	key_match_a: assert property (stop_edge_s ##0 good_frame_s |=> match_o ##1 !match_o) // RL22
		else $error("matching frame gave no match pulse");
	key_off_a: assert property (key_off_i |=> state_reg == KEY_WAIT_IDLE && !match_o) // RL25
		else $error("matcher ran while switched off");
	mid_abort_a: assert property (state_reg == KEY_RECEIVE && idle_met && !key_off_i |=> state_reg == KEY_WAIT_IDLE) // RL24
		else $error("long high clock did not reset matcher");
	arm_idle_a: assert property (state_reg == KEY_WAIT_IDLE && idle_met && !key_off_i |=> state_reg == KEY_ARMED) // RL23
		else $error("matcher not armed after idle period");
	bad_start_a: assert property (state_reg == KEY_ARMED && kbd_fall_i && kbd_data_i && !key_off_i
		|=> state_reg == KEY_WAIT_IDLE) // RL21
		else $error("start bit of one was accepted");
endmodule // key_code_matcher

// [design/wake_event_aggregator.sv]
// wake event aggregator: banked wake status, alarm routing and wake pin drive
module wake_event_aggregator import wake_pkg::*; #(
	parameter int KBD_IDLE_CYCLES = KBD_IDLE_CYC
) (
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	input  wire io_req_s     io_req_i,
	output logic [7:0]       io_rdata_o,
	input  wire logic        ring_indicator_one_n_i,
	input  wire logic        ring_indicator_two_n_i,
	input  wire logic        kbd_clk_i,
	input  wire logic        kbd_data_i,
	input  wire logic        mouse_data_i,
	input  wire logic        fan_tach_i,
	input  wire logic        watchdog_i,
	input  wire logic [39:0] gpio_i,
	input  wire logic [5:0]  dev_irq_i,
	input  wire logic        kbc_port_bit_a_i,
	input  wire logic        kbc_port_bit_b_i,
	input  wire logic        rtc_alarm_i,
	input  wire logic        power_button_n_i,
	input  wire logic        alarm_missed_i,
	output logic             supply_on_n_o,
	output logic             wake_event_out_n_o,
	output logic             wake_event_oe_o,
	output logic             smi_event_o
);
	logic [NSYNC-1:0] raw, lvl, rise, fall;
	logic             key_match;
	logic [NSRC-1:0]  pol_eff, ee_eff, pol_rd, ee_rd, det, clr;
	logic [NSRC-1:0]  sts_reg, sts_next, en_reg, en_next;
	logic [7:0]       base_hi_reg, base_lo_reg, clock_reg, supply_reg;
	logic [7:0]       global_reg, smi_ctrl_reg, acpi_event_status_reg_reg, pm1_en_reg;
	logic [7:0]       edge_sel_reg, pin_ctrl_reg, scan_reg, sci_ctrl_reg;
	logic [7:0]       pm1_set, pm1_clr, acpi_event_status_reg_next, rd_mux, rdata_reg;
	logic             supply_on_n_reg, supply_on_n_next;
	logic             wake_act_reg, wake_next, smi_reg, smi_next;
	logic             pin_out_reg, pin_oe_reg, pin_level;

	// source bit n sits in bank n/8, bit n%8
	assign raw = {alarm_missed_i, power_button_n_i, rtc_alarm_i, kbd_clk_i,
		gpio_i[39:32], kbc_port_bit_b_i, kbc_port_bit_a_i, dev_irq_i, gpio_i[31:0],
		1'h0, watchdog_i, key_match, fan_tach_i, mouse_data_i, kbd_data_i,
		ring_indicator_two_n_i, ring_indicator_one_n_i}; // RL6 RL13 RL18

	wake_edge_detect #(
		.W(NSYNC)
	) u_sync (
		.core_clk_i(core_clk_i),
		.sys_rst_i (sys_rst_i),
		.raw_i     (raw),
		.level_o   (lvl),
		.rise_o    (rise),
		.fall_o    (fall)
	);

	key_code_matcher #(
		.IDLE_CYCLES(KBD_IDLE_CYCLES)
	) u_key (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.kbd_clk_i  (lvl[IDX_KBD_CLK]),
		.kbd_fall_i (fall[IDX_KBD_CLK]),
		.kbd_data_i (lvl[IDX_KBD_DATA]),
		.scan_code_i(scan_reg), // RL19
		.key_off_i  (clock_reg[CLK_KEY_OFF_BIT]),
		.match_o    (key_match)
	);

	// address decode; the runtime block is assumed 128-byte aligned
	logic [15:0] base;
	logic [6:0]  off;
	logic [2:0]  bank;
	logic        rt_hit, rt_wr, rt_rd, cfg_wr, cfg_rd, bank_ok;
	logic        sts_wr, en_wr, pol_wr, ee_wr;
	assign base = {base_hi_reg, base_lo_reg};
	assign off = io_req_i.addr[6:0];
	assign bank = off[2:0];
	assign bank_ok = bank != 3'h7;
	assign rt_hit = !io_req_i.cfg && io_req_i.addr[15:7] == base[15:7]; // RL17
	assign rt_wr = rt_hit && io_req_i.wr;
	assign rt_rd = rt_hit && io_req_i.rd;
	assign cfg_wr = io_req_i.cfg && io_req_i.wr;
	assign cfg_rd = io_req_i.cfg && io_req_i.rd;
	assign sts_wr = rt_wr && bank_ok && off[6:3] == RT_STS_BASE[6:3];
	assign en_wr = rt_wr && bank_ok && off[6:3] == RT_EN_BASE[6:3];
	assign pol_wr = rt_wr && bank_ok && off[6:3] == RT_POL_BASE[6:3];
	assign ee_wr = rt_wr && bank_ok && off[6:3] == RT_EE_BASE[6:3];

	for (genvar b = 0; b < NBANK; b++) begin : g_bank
		logic hit;
		assign hit = bank == 3'(b);
		assign clr[b*8 +: 8] = (sts_wr && hit) ? io_req_i.data : 8'h00; // RL10 RL16
		assign en_next[b*8 +: 8] = (en_wr && hit) ? io_req_i.data : en_reg[b*8 +: 8];
		if (b == 0) begin : g_pins
			// ring, keyboard and mouse lines are active low
			assign pol_eff[7:0] = BANK1_POL;
			assign ee_eff[7:0] = 8'h00;
			assign pol_rd[7:0] = 8'h00;
			assign ee_rd[7:0] = 8'h00;
		end else if (b == PORT_BANK) begin : g_ports
			assign pol_eff[b*8 +: 8] = BANK6_POL; // RL14
			assign ee_eff[b*8 +: 8] = {edge_sel_reg[1:0], 6'h00}; // RL14
			assign pol_rd[b*8 +: 8] = 8'h00;
			assign ee_rd[b*8 +: 8] = 8'h00;
		end else begin : g_gpio
			logic [7:0] pol_reg, ee_reg;
			always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					pol_reg <= BYTE_RST;
					ee_reg <= BYTE_RST;
				end else begin
					if (pol_wr && hit)
						pol_reg <= io_req_i.data;
					if (ee_wr && hit)
						ee_reg <= io_req_i.data;
				end
			end
			assign pol_eff[b*8 +: 8] = pol_reg; // RL11
			assign ee_eff[b*8 +: 8] = ee_reg; // RL12
			assign pol_rd[b*8 +: 8] = pol_reg;
			assign ee_rd[b*8 +: 8] = ee_reg;
		end
	end

	// edge choice per source, then sticky status where a new edge beats a clear
	assign det = (ee_eff & (rise[NSRC-1:0] | fall[NSRC-1:0]))
		| (~ee_eff & ((pol_eff & fall[NSRC-1:0]) | (~pol_eff & rise[NSRC-1:0]))); // RL11 RL12 RL14
	assign sts_next = (sts_reg & ~clr) | det; // RL9 RL15

	logic summary;
	assign summary = |(sts_reg & en_reg); // RL10 RL20

	// acpi events: the alarm lives only here, never in the banks
	logic alarm_evt, pwrbtn_evt, pm1_fire, sci_on;
	assign alarm_evt = rise[IDX_ALARM] | (rise[IDX_MISSED] & supply_reg[SUP_REMEMBER_BIT]); // RL5
	assign pwrbtn_evt = fall[IDX_PWRBTN];
	assign pm1_set = (8'(alarm_evt) << PM1_ALARM_BIT) | (8'(pwrbtn_evt) << PM1_PWRBTN_BIT); // RL1
	assign pm1_clr = (rt_wr && off == RT_ACPI_EVENT_STATUS_REG) ? io_req_i.data : 8'h00;
	assign acpi_event_status_reg_next = (acpi_event_status_reg_reg & ~pm1_clr) | pm1_set;
	assign pm1_fire = |(acpi_event_status_reg_reg & pm1_en_reg); // RL4
	assign sci_on = sci_ctrl_reg[SCI_ROUTE_ENABLE_BIT];

	// power button wakes regardless of its enable; soft-off loses to a pending wake
	assign supply_on_n_next = (pm1_fire || acpi_event_status_reg_reg[PM1_PWRBTN_BIT]) ? 1'h0
		: (cfg_wr && io_req_i.addr[7:0] == CFG_SUPPLY && io_req_i.data[SUP_PSOFF_BIT]) ? 1'h1
		: supply_on_n_reg; // RL1
	assign wake_next = (global_reg[GLOBAL_EN_BIT] && summary) || (sci_on && pm1_fire); // RL2 RL4 RL8
	assign smi_next = !sci_on && !supply_reg[SUP_SEL_N_BIT] && smi_ctrl_reg[SMI_OE_BIT] && pm1_fire; // RL3

	// open drain only pulls low; push-pull drives both levels
	assign pin_level = pin_ctrl_reg[PIN_POL_HIGH_BIT] ? wake_next : !wake_next; // RL7

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sts_reg <= '0;
			en_reg <= '0;
			acpi_event_status_reg_reg <= BYTE_RST;
			supply_on_n_reg <= 1'h1;
			wake_act_reg <= 1'h0;
			smi_reg <= 1'h0;
			pin_out_reg <= 1'h0;
			pin_oe_reg <= 1'h0;
		end else begin
			sts_reg <= sts_next;
			en_reg <= en_next;
			acpi_event_status_reg_reg <= acpi_event_status_reg_next;
			supply_on_n_reg <= supply_on_n_next;
			wake_act_reg <= wake_next;
			smi_reg <= smi_next;
			pin_out_reg <= pin_ctrl_reg[PIN_PUSH_PULL_BIT] && pin_level; // RL7
			pin_oe_reg <= pin_ctrl_reg[PIN_PUSH_PULL_BIT] || !pin_level; // RL7
		end
	end

	// configuration space registers
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			base_hi_reg <= BYTE_RST;
			base_lo_reg <= BYTE_RST;
			clock_reg <= BYTE_RST; // RL25
			supply_reg <= BYTE_RST;
		end else if (cfg_wr) begin
			if (io_req_i.addr[7:0] == CFG_BASE_HI)
				base_hi_reg <= io_req_i.data;
			else if (io_req_i.addr[7:0] == CFG_BASE_LO)
				base_lo_reg <= io_req_i.data;
			else if (io_req_i.addr[7:0] == CFG_CLOCK)
				clock_reg <= io_req_i.data;
			else if (io_req_i.addr[7:0] == CFG_SUPPLY)
				supply_reg <= io_req_i.data & ~(8'h01 << SUP_PSOFF_BIT);
		end
	end

	// runtime block control registers
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			global_reg <= BYTE_RST;
			smi_ctrl_reg <= BYTE_RST;
			pm1_en_reg <= BYTE_RST;
			edge_sel_reg <= BYTE_RST;
			pin_ctrl_reg <= BYTE_RST;
			scan_reg <= BYTE_RST;
			sci_ctrl_reg <= BYTE_RST;
		end else if (rt_wr) begin
			if (off == RT_GLOBAL)
				global_reg <= io_req_i.data;
			else if (off == RT_SMI_CTRL)
				smi_ctrl_reg <= io_req_i.data;
			else if (off == RT_PM1_EN)
				pm1_en_reg <= io_req_i.data;
			else if (off == RT_EDGE_SEL)
				edge_sel_reg <= io_req_i.data;
			else if (off == RT_PIN_CTRL)
				pin_ctrl_reg <= io_req_i.data;
			else if (off == RT_SCAN)
				scan_reg <= io_req_i.data;
			else if (off == RT_SCI_CTRL)
				sci_ctrl_reg <= io_req_i.data;
		end
	end

	always_comb begin
		rd_mux = 8'h00;
		if (cfg_rd) begin
			if (io_req_i.addr[7:0] == CFG_BASE_HI)
				rd_mux = base_hi_reg;
			else if (io_req_i.addr[7:0] == CFG_BASE_LO)
				rd_mux = base_lo_reg;
			else if (io_req_i.addr[7:0] == CFG_CLOCK)
				rd_mux = clock_reg;
			else if (io_req_i.addr[7:0] == CFG_SUPPLY)
				rd_mux = supply_reg;
		end else if (rt_rd) begin
			if (off == RT_SUMMARY)
				rd_mux = {7'h00, summary};
			else if (off == RT_GLOBAL)
				rd_mux = global_reg;
			else if (bank_ok && off[6:3] == RT_STS_BASE[6:3])
				rd_mux = sts_reg[bank*8 +: 8];
			else if (bank_ok && off[6:3] == RT_EN_BASE[6:3])
				rd_mux = en_reg[bank*8 +: 8];
			else if (bank_ok && off[6:3] == RT_POL_BASE[6:3])
				rd_mux = pol_rd[bank*8 +: 8];
			else if (bank_ok && off[6:3] == RT_EE_BASE[6:3])
				rd_mux = ee_rd[bank*8 +: 8];
			else if (off == RT_SMI_CTRL)
				rd_mux = smi_ctrl_reg;
			else if (off == RT_ACPI_EVENT_STATUS_REG)
				rd_mux = acpi_event_status_reg_reg;
			else if (off == RT_PM1_EN)
				rd_mux = pm1_en_reg;
			else if (off == RT_EDGE_SEL)
				rd_mux = edge_sel_reg;
			else if (off == RT_PIN_CTRL)
				rd_mux = pin_ctrl_reg;
			else if (off == RT_SCAN)
				rd_mux = scan_reg;
			else if (off == RT_SCI_CTRL)
				rd_mux = sci_ctrl_reg;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			rdata_reg <= 8'h00;
		else if (cfg_rd || rt_rd)
			rdata_reg <= rd_mux;
	end

	assign io_rdata_o = rdata_reg;
	assign supply_on_n_o = supply_on_n_reg;
	assign wake_event_out_n_o = pin_out_reg;
	assign wake_event_oe_o = pin_oe_reg;
	assign smi_event_o = smi_reg;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	logic alarm_on;
	assign alarm_on = acpi_event_status_reg_reg[PM1_ALARM_BIT] && pm1_en_reg[PM1_ALARM_BIT];

	alarm_supply_a: assert property (alarm_on |=> !supply_on_n_o) // RL1
		else $error("enabled alarm did not turn supply on");
	alarm_sci_a: assert property (alarm_on && sci_on |=> wake_act_reg) // RL2
		else $error("routed alarm did not raise wake");
	alarm_smi_a: assert property (alarm_on && !sci_on && !supply_reg[SUP_SEL_N_BIT] && smi_ctrl_reg[SMI_OE_BIT]
		|=> smi_event_o) // RL3
		else $error("unrouted alarm did not raise smi");
	no_global_a: assert property (alarm_on && sci_on && !global_reg[GLOBAL_EN_BIT] |=> wake_act_reg) // RL4
		else $error("alarm wake depended on global enable");
	global_gate_a: assert property (!global_reg[GLOBAL_EN_BIT] && !(sci_on && pm1_fire) |=> !wake_act_reg) // RL8
		else $error("wake raised with global enable clear");
	set_wins_a: assert property (|det |=> (sts_reg & $past(det)) == $past(det)) // RL9
		else $error("status edge lost");
	rise_set_a: assert property (|(rise[NSRC-1:0] & ~pol_eff & ~ee_eff)
		|=> (sts_reg & $past(rise[NSRC-1:0] & ~pol_eff & ~ee_eff)) != '0) // RL11
		else $error("rising edge did not set status");
	either_edge_a: assert property (|(fall[NSRC-1:0] & ee_eff)
		|=> (sts_reg & $past(fall[NSRC-1:0] & ee_eff)) != '0) // RL12
		else $error("either edge mode missed falling edge");
	clear_drop_a: assert property (sts_wr && ((sts_reg & en_reg & ~clr) == '0) && det == '0
		&& !(sci_on && pm1_fire) |=> ##1 !wake_act_reg) // RL10
		else $error("wake stayed after clearing all status");
	pin_default_a: assert property (wake_act_reg && !$past(pin_ctrl_reg[PIN_PUSH_PULL_BIT])
		&& !$past(pin_ctrl_reg[PIN_POL_HIGH_BIT]) |-> wake_event_oe_o && !wake_event_out_n_o) // RL7
		else $error("open drain active low pin not pulled low");
endmodule // wake_event_aggregator

// [verification/wake_chipset_model.sv]
// chipset side of the wake pin: pulled-up shared line
module wake_chipset_model (
	input  wire logic wake_out_n_i,
	input  wire logic wake_oe_i,
	output logic      line_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// board pull-up owns the line whenever the pin is released
	assign line_o = wake_oe_i ? wake_out_n_i : 1'b1;
endmodule // wake_chipset_model

// [verification/wake_event_aggregator_test.sv]
// self-checking bench of the wake event aggregator
module wake_event_aggregator_test import wake_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] BASE = 16'h0400;
	logic        core_clk_i;
	logic        sys_rst_i;
	io_req_s     io_req;
	logic [7:0]  rdata;
	logic        ri1_n, ri2_n, kclk, kdat, mdat, fan, wdt, pa, pb, alarm, pbtn_n, missed;
	logic [39:0] gpio;
	logic [5:0]  irq;
	logic        supply_n, wake_n, wake_oe, smi, line;
	int          mismatches;
	int          comparisons;
	int          cycles;

	wake_event_aggregator #(.KBD_IDLE_CYCLES(20)) wake_event_aggregator_i (
		.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .io_req_i(io_req), .io_rdata_o(rdata),
		.ring_indicator_one_n_i(ri1_n), .ring_indicator_two_n_i(ri2_n), .kbd_clk_i(kclk),
		.kbd_data_i(kdat), .mouse_data_i(mdat), .fan_tach_i(fan), .watchdog_i(wdt), .gpio_i(gpio),
		.dev_irq_i(irq), .kbc_port_bit_a_i(pa), .kbc_port_bit_b_i(pb), .rtc_alarm_i(alarm),
		.power_button_n_i(pbtn_n), .alarm_missed_i(missed), .supply_on_n_o(supply_n),
		.wake_event_out_n_o(wake_n), .wake_event_oe_o(wake_oe), .smi_event_o(smi));
	wake_chipset_model wake_chipset_model_i (.wake_out_n_i(wake_n), .wake_oe_i(wake_oe), .line_o(line));

	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// request held for exactly one taking edge, data sampled just after it
	task automatic acc(input logic c, input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		#1 io_req = '{cfg: c, wr: w, rd: ~w, addr: a, data: d};
		@(posedge core_clk_i);
		#1 io_req = '0;
	endtask

	task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
		acc(1'b1, 1'b1, {8'h00, a}, d);
	endtask

	task automatic rt_wr(input logic [6:0] off, input logic [7:0] d);
		acc(1'b0, 1'b1, BASE | {9'h000, off}, d);
	endtask

	task automatic rt_rd(input logic [6:0] off, input logic [7:0] exp);
		acc(1'b0, 1'b0, BASE | {9'h000, off}, 8'h00);
		chk(rdata, exp);
	endtask

	// start 0, data lsb first, odd parity, stop 1, after a long idle high; n below 11 cuts the frame
	task automatic key_frame(input logic [7:0] code, input int n);
		logic [10:0] bits;
		bits = {1'b1, ~^code, code, 1'b0};
		cyc(30);
		for (int i = 0; i < n; i++) begin
			kdat = bits[i];
			cyc(4);
			kclk = 1'b0;
			cyc(4);
			kclk = 1'b1;
			cyc(4);
		end
		kdat = 1'b1;
		cyc(30);
	endtask

	initial begin
		{sys_rst_i, ri1_n, ri2_n, kclk, kdat, mdat, pa, pb, pbtn_n} = 9'h1FF;
		{fan, wdt, alarm, missed, gpio, irq, io_req} = '0;
		cyc(12);
		sys_rst_i = 1'b0;
		chk1(supply_n, 1'b1);
		chk1(wake_oe, 1'b0);
		chk1(smi, 1'b0);
		cfg_wr(CFG_BASE_HI, 8'h04);
		cfg_wr(CFG_BASE_LO, 8'h00);
		rt_wr(RT_SCAN, 8'h1C);
		rt_rd(RT_SCAN, 8'h1C);
		rt_rd(RT_SUMMARY, 8'h00);
		// same offset outside the block must miss and keep the zero read before it
		acc(1'b0, 1'b0, 16'h085F, 8'h00);
		chk(rdata, 8'h00);
		ri1_n = 1'b0;
		cyc(4);
		rt_rd(RT_STS_BASE, 8'h01);
		rt_wr(RT_EN_BASE, 8'h01);
		cyc(2);
		chk1(line, 1'b1);
		rt_wr(RT_GLOBAL, 8'h01);
		cyc(2);
		chk1(line, 1'b0);
		rt_rd(RT_SUMMARY, 8'h01);
		rt_wr(RT_STS_BASE, 8'h01);
		ri1_n = 1'b1;
		cyc(2);
		rt_rd(RT_SUMMARY, 8'h00);
		chk1(line, 1'b1);
		rt_wr(RT_EN_BASE, 8'h10);
		rt_wr(RT_PIN_CTRL, 8'h82);
		fan = 1'b1;
		cyc(5);
		chk1(wake_oe, 1'b1);
		chk1(wake_n, 1'b1);
		rt_wr(RT_STS_BASE, 8'h10);
		cyc(2);
		chk1(wake_n, 1'b0);
		rt_wr(RT_PIN_CTRL, 8'h00);
		rt_wr(RT_EN_BASE, 8'h00);
		rt_wr(RT_POL_BASE + 7'h01, 8'h02);
		rt_wr(RT_EE_BASE + 7'h01, 8'h04);
		gpio[2:0] = 3'h7;
		cyc(4);
		rt_rd(RT_STS_BASE + 7'h01, 8'h05);
		rt_wr(RT_STS_BASE + 7'h01, 8'hFF);
		gpio[2:0] = 3'h0;
		cyc(4);
		rt_rd(RT_STS_BASE + 7'h01, 8'h06);
		pb = 1'b0;
		cyc(4);
		rt_rd(RT_STS_BASE + 7'h05, 8'h80);
		rt_wr(RT_STS_BASE + 7'h05, 8'h80);
		rt_wr(RT_EDGE_SEL, 8'h02);
		rt_wr(RT_EN_BASE + 7'h05, 8'h80);
		pb = 1'b1;
		cyc(5);
		chk1(line, 1'b0);
		rt_wr(RT_STS_BASE + 7'h05, 8'h80);
		cyc(2);
		chk1(line, 1'b1);
		key_frame(8'h1C, 11);
		rt_rd(RT_STS_BASE, 8'h24);
		cfg_wr(CFG_CLOCK, 8'h02);
		rt_wr(RT_STS_BASE, 8'hFF);
		key_frame(8'h1C, 11);
		rt_rd(RT_STS_BASE, 8'h04);
		cfg_wr(CFG_CLOCK, 8'h00);
		rt_wr(RT_STS_BASE, 8'hFF);
		// a cut frame must be dropped so the next full frame still matches
		key_frame(8'h1C, 4);
		key_frame(8'h1C, 11);
		rt_rd(RT_STS_BASE, 8'h24);
		rt_wr(RT_GLOBAL, 8'h00);
		rt_wr(RT_PM1_EN, 8'h04);
		rt_wr(RT_SCI_CTRL, 8'h01);
		alarm = 1'b1;
		cyc(4);
		chk1(supply_n, 1'b0);
		chk1(line, 1'b0);
		rt_rd(RT_ACPI_EVENT_STATUS_REG, 8'h04);
		rt_wr(RT_ACPI_EVENT_STATUS_REG, 8'h04);
		rt_wr(RT_SCI_CTRL, 8'h00);
		rt_wr(RT_SMI_CTRL, 8'h80);
		alarm = 1'b0;
		cyc(4);
		alarm = 1'b1;
		cyc(4);
		chk1(smi, 1'b1);
		chk1(line, 1'b1);
		rt_wr(RT_ACPI_EVENT_STATUS_REG, 8'h04);
		cfg_wr(CFG_SUPPLY, 8'h21);
		cyc(2);
		chk1(supply_n, 1'b1);
		missed = 1'b1;
		cyc(4);
		chk1(supply_n, 1'b0);
		rt_rd(RT_ACPI_EVENT_STATUS_REG, 8'h04);
		rt_wr(RT_ACPI_EVENT_STATUS_REG, 8'h04);
		cfg_wr(CFG_SUPPLY, 8'h01);
		chk1(supply_n, 1'b1);
		pbtn_n = 1'b0;
		cyc(4);
		chk1(supply_n, 1'b0);
		rt_rd(RT_ACPI_EVENT_STATUS_REG, 8'h01);
		{ri2_n, mdat, wdt, irq[0], gpio[32]} = 5'h07;
		cyc(4);
		rt_rd(RT_STS_BASE, 8'h6E);
		rt_rd(RT_STS_BASE + 7'h05, 8'h01);
		rt_rd(RT_STS_BASE + 7'h06, 8'h01);
		end_of_test();
	end
endmodule // wake_event_aggregator_test
